//--- hdl/serdes_dbg_pkg.sv
// Overview of operation
// - per-lane 16-bit read-only eye mismatch count
// - lane counters consecutive, lane zero lowest address
// - threshold about 15 mV times code 2-15
// - threshold applies only when enabled, all lanes
// - gain steps only after configured votes accumulate
// - vote code map: 0=511, 2..9=2^(n-1)-1
// - freeze bit 0 stops recovery tracking, holds phase
// - phase register returns selected lane's phase
// - phase reported Gray coded, not binary
// - done vector bit n set when lane n done
`default_nettype none
package serdes_dbg_pkg;
  localparam int unsigned NUM_LANES  = 16;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned COUNT_W    = 16;
  localparam int unsigned PHASE_W    = 8;
  localparam int unsigned LANE_SEL_W = 4;
  localparam int unsigned VOTE_W     = 10;
  localparam int unsigned LEVEL_W    = 8;

  localparam logic [ADDR_W-1:0] ADDR_SCAN_DONE_LO = 10'h1f6;
  localparam logic [ADDR_W-1:0] ADDR_SCAN_DONE_HI = 10'h1f7;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_FIRST  = 10'h210;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LAST   = 10'h22f;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_THRESH  = 10'h234;
  localparam logic [ADDR_W-1:0] ADDR_VOTE_SIZE    = 10'h235;
  localparam logic [ADDR_W-1:0] ADDR_FREEZE       = 10'h238;
  localparam logic [ADDR_W-1:0] ADDR_PHASE        = 10'h239;

  localparam logic [DATA_W-1:0] RST_LOSS_THRESH = 8'h08;
  localparam logic [DATA_W-1:0] RST_VOTE_SIZE   = 8'h00;
  localparam logic [DATA_W-1:0] RST_FREEZE      = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA   = 8'h00;

  localparam int unsigned FREEZE_BIT  = 0;
  localparam int unsigned CODE_MSB    = 3;
  localparam logic [3:0] LOSS_MIN_CODE = 4'h2;
  localparam logic [LEVEL_W-1:0] LOSS_STEP_MV = 8'h0f;
  localparam logic [3:0] VOTE_CODE_DEFAULT = 4'h0;
  localparam logic [3:0] VOTE_CODE_MIN     = 4'h2;
  localparam logic [3:0] VOTE_CODE_MAX     = 4'h9;
  localparam logic [VOTE_W-2:0] VOTE_DEFAULT_COUNT = 9'h1ff;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  // reserved codes fall back to the default 511 votes
  function automatic logic [VOTE_W-2:0] votes_required(input logic [3:0] code);
    logic [VOTE_W-2:0] one;
    one = 9'h001;
    if (code >= VOTE_CODE_MIN && code <= VOTE_CODE_MAX) begin
      votes_required = (one << (code - 4'h1)) - one;
    end else begin
      votes_required = VOTE_DEFAULT_COUNT;
    end
  endfunction : votes_required

  function automatic logic [PHASE_W-1:0] to_gray(input logic [PHASE_W-1:0] bin);
    to_gray = bin ^ (bin >> 1);
  endfunction : to_gray
endpackage : serdes_dbg_pkg
`default_nettype wire

//--- hdl/eye_mismatch_counter.sv
`default_nettype none
module eye_mismatch_counter
  import serdes_dbg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               scan_start,
  input  wire logic               mismatch,
  output logic [COUNT_W-1:0]      count
);
  // saturates so a long scan never wraps to a small count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (scan_start) begin
      count <= '0;
    end else if (mismatch && count != '1) begin
      count <= count + 16'h0001;
    end
  end
endmodule : eye_mismatch_counter
`default_nettype wire

//--- hdl/equalizer_vote_accumulator.sv
`default_nettype none
module equalizer_vote_accumulator
  import serdes_dbg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic [VOTE_W-2:0]  votes_needed,
  input  wire logic               vote_up,
  input  wire logic               vote_down,
  output logic                    gain_inc,
  output logic                    gain_dec
);
  logic signed [VOTE_W-1:0] net;
  logic signed [VOTE_W-1:0] next_net;
  logic signed [VOTE_W-1:0] limit;

  always_comb begin
    limit = signed'({1'b0, votes_needed});
    next_net = net;
    if (vote_up && !vote_down) begin
      next_net = net + 10'sd1;
    end else if (vote_down && !vote_up) begin
      next_net = net - 10'sd1;
    end
  end

  // gain moves only once the net vote reaches the limit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      net      <= '0;
      gain_inc <= 1'b0;
      gain_dec <= 1'b0;
    end else begin
      gain_inc <= next_net >= limit;
      gain_dec <= next_net <= -limit;
      if (next_net >= limit || next_net <= -limit) begin
        net <= '0;
      end else begin
        net <= next_net;
      end
    end
  end
endmodule : equalizer_vote_accumulator
`default_nettype wire

//--- hdl/serdes_rx_debug_status_regs.sv
`default_nettype none
module serdes_rx_debug_status_regs
  import serdes_dbg_pkg::*;
(
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  input  wire reg_req_s                            reg_req,
  output logic [DATA_W-1:0]                        reg_rdata,
  output logic                                     reg_rvalid,
  input  wire logic [NUM_LANES-1:0]                eye_scan_start,
  input  wire logic [NUM_LANES-1:0]                eye_scan_mismatch,
  input  wire logic [NUM_LANES-1:0]                eye_scan_done,
  input  wire logic                                signal_loss_enable,
  output logic [3:0]                               signal_loss_threshold,
  output logic                                     signal_loss_active,
  output logic [LEVEL_W-1:0]                       signal_loss_level_mv,
  input  wire logic [NUM_LANES-1:0]                eq_vote_up,
  input  wire logic [NUM_LANES-1:0]                eq_vote_down,
  output logic [NUM_LANES-1:0]                     eq_gain_inc,
  output logic [NUM_LANES-1:0]                     eq_gain_dec,
  output logic                                     recovery_freeze,
  input  wire logic [NUM_LANES-1:0][PHASE_W-1:0]   recovery_phase_bin,
  input  wire logic [LANE_SEL_W-1:0]               debug_lane_select
);
  logic [DATA_W-1:0]                    loss_reg;
  logic [DATA_W-1:0]                    vote_reg;
  logic [DATA_W-1:0]                    freeze_reg;
  logic [PHASE_W-1:0]                   phase_gray;
  logic [NUM_LANES-1:0][COUNT_W-1:0]    counts;
  logic [VOTE_W-2:0]                    votes_needed;
  logic [DATA_W-1:0]                    next_rdata;
  logic [ADDR_W-1:0]                    count_off;

  // writes to read-only or unmapped addresses are dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      loss_reg <= RST_LOSS_THRESH;
    end else if (reg_req.wr && reg_req.addr == ADDR_LOSS_THRESH) begin
      loss_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vote_reg <= RST_VOTE_SIZE;
    end else if (reg_req.wr && reg_req.addr == ADDR_VOTE_SIZE) begin
      vote_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      freeze_reg <= RST_FREEZE;
    end else if (reg_req.wr && reg_req.addr == ADDR_FREEZE) begin
      freeze_reg <= reg_req.wdata;
    end
  end

  assign signal_loss_threshold = loss_reg[CODE_MSB:0];
  assign signal_loss_active    = signal_loss_enable;

  // one threshold for all lanes; reserved codes give no level
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      signal_loss_level_mv <= '0;
    end else if (signal_loss_enable && loss_reg[CODE_MSB:0] >= LOSS_MIN_CODE) begin
      signal_loss_level_mv <= 8'(LOSS_STEP_MV * loss_reg[CODE_MSB:0]);
    end else begin
      signal_loss_level_mv <= '0;
    end
  end

  assign recovery_freeze = freeze_reg[FREEZE_BIT];

  // capture also holds while frozen, so readback never tears
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_gray <= '0;
    end else if (!freeze_reg[FREEZE_BIT]) begin
      phase_gray <= to_gray(recovery_phase_bin[debug_lane_select]);
    end
  end

  assign votes_needed = votes_required(vote_reg[CODE_MSB:0]);

  for (genvar lane = 0; lane < NUM_LANES; lane++) begin : g_lane
    eye_mismatch_counter u_count (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .scan_start (eye_scan_start[lane]),
      .mismatch   (eye_scan_mismatch[lane]),
      .count      (counts[lane])
    );
    equalizer_vote_accumulator u_vote (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .votes_needed (votes_needed),
      .vote_up      (eq_vote_up[lane]),
      .vote_down    (eq_vote_down[lane]),
      .gain_inc     (eq_gain_inc[lane]),
      .gain_dec     (eq_gain_dec[lane])
    );
  end

  assign count_off = reg_req.addr - ADDR_COUNT_FIRST;

  always_comb begin
    next_rdata = UNMAPPED_DATA;
    if (reg_req.addr >= ADDR_COUNT_FIRST && reg_req.addr <= ADDR_COUNT_LAST) begin
      // two bytes per lane, low byte first, lane zero lowest
      if (count_off[0]) begin
        next_rdata = counts[count_off[4:1]][COUNT_W-1:DATA_W];
      end else begin
        next_rdata = counts[count_off[4:1]][DATA_W-1:0];
      end
    end else begin
      unique case (reg_req.addr)
        ADDR_SCAN_DONE_LO: next_rdata = eye_scan_done[DATA_W-1:0];
        ADDR_SCAN_DONE_HI: next_rdata = eye_scan_done[NUM_LANES-1:DATA_W];
        ADDR_LOSS_THRESH:  next_rdata = loss_reg;
        ADDR_VOTE_SIZE:    next_rdata = vote_reg;
        ADDR_FREEZE:       next_rdata = freeze_reg;
        ADDR_PHASE:        next_rdata = phase_gray;
        default:           next_rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end
endmodule : serdes_rx_debug_status_regs
`default_nettype wire

//--- verif/rx_dbg_props.sv
`default_nettype none
module rx_dbg_props
  import serdes_dbg_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire reg_req_s             reg_req,
  input wire logic [DATA_W-1:0]    reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic [NUM_LANES-1:0] eye_scan_done,
  input wire logic                 signal_loss_enable,
  input wire logic [3:0]           signal_loss_threshold,
  input wire logic                 signal_loss_active,
  input wire logic [LEVEL_W-1:0]   signal_loss_level_mv,
  input wire logic                 recovery_freeze
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_read_valid: assert property (reg_req.rd |=> reg_rvalid)
    else $error("no rvalid after read");
  a_idle_quiet: assert property (!reg_req.rd |=> !reg_rvalid)
    else $error("rvalid without read");
  a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("rdata moved without read");
  a_thr_write: assert property (reg_req.wr && reg_req.addr == ADDR_LOSS_THRESH
    |=> signal_loss_threshold == $past(reg_req.wdata[3:0])) else $error("threshold write lost");
  a_loss_follow: assert property (signal_loss_active == signal_loss_enable)
    else $error("active not following enable");
  a_level_off: assert property (!signal_loss_enable |=> signal_loss_level_mv == 8'h00)
    else $error("level while disabled");
  a_frz_write: assert property (reg_req.wr && reg_req.addr == ADDR_FREEZE
    |=> recovery_freeze == $past(reg_req.wdata[0])) else $error("freeze write lost");
  a_done_read: assert property (reg_req.rd && reg_req.addr == ADDR_SCAN_DONE_LO
    |=> reg_rdata == $past(eye_scan_done[7:0])) else $error("done vector wrong");
endmodule : rx_dbg_props
bind serdes_rx_debug_status_regs rx_dbg_props u_props (.*);
`default_nettype wire

//--- verif/tb_serdes_rx_debug_status_regs.sv
`default_nettype none
module tb_serdes_rx_debug_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_dbg_pkg::*;
  logic core_clk, resetn, reg_rvalid, signal_loss_enable, signal_loss_active, recovery_freeze;
  reg_req_s reg_req;
  logic [7:0] reg_rdata, signal_loss_level_mv;
  logic [3:0] signal_loss_threshold, debug_lane_select;
  logic [15:0] eye_scan_start, eye_scan_mismatch, eye_scan_done;
  logic [15:0] eq_vote_up, eq_vote_down, eq_gain_inc, eq_gain_dec;
  logic [15:0][7:0] recovery_phase_bin;
  int n_mismatch = 0;
  int n_tests = 0;
  serdes_rx_debug_status_regs dut (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask : tick
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    reg_req = '0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string nm);
    reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick(1);
    reg_req = '0;
    chk("rvalid", 16'h1, {15'h0, reg_rvalid});
    chk(nm, {8'h00, e}, {8'h00, reg_rdata});
    tick(1);
  endtask : rd
  task automatic t_loss;
    rd(ADDR_LOSS_THRESH, 8'h08, "thr rst");
    rd(ADDR_VOTE_SIZE, 8'h00, "vote rst");
    rd(ADDR_FREEZE, 8'h00, "frz rst");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_LOSS_THRESH, 8'(c));
      signal_loss_enable = c[0];
      tick(2);
      chk("thr", 16'(c), {12'h0, signal_loss_threshold});
      chk("mv", (c > 1 && c[0]) ? 16'(15 * c) : 16'h0, {8'h0, signal_loss_level_mv});
    end
  endtask : t_loss
  task automatic t_count;
    eye_scan_start = 16'h8018;
    tick(1);
    eye_scan_start = '0;
    for (int i = 0; i < 5; i++) begin
      eye_scan_mismatch = (i == 0) ? 16'h8018 : (i == 1) ? 16'h0018 : 16'h0008;
      tick(1);
    end
    eye_scan_mismatch = '0;
    eye_scan_done = 16'ha5c3;
    wr(10'h216, 8'hff);
    rd(10'h216, 8'h05, "cnt3");
    rd(10'h217, 8'h00, "cnt3 hi");
    rd(10'h218, 8'h02, "cnt4");
    rd(10'h22e, 8'h01, "cnt15");
    rd(ADDR_SCAN_DONE_LO, 8'hc3, "done lo");
    rd(ADDR_SCAN_DONE_HI, 8'ha5, "done hi");
    rd(10'h3ff, 8'h00, "unmapped");
    eye_scan_start = 16'h0008;
    tick(1);
    eye_scan_start = '0;
    rd(10'h216, 8'h00, "cnt3 clr");
  endtask : t_count
  task automatic t_vote;
    logic [3:0] code [5] = '{4'h2, 4'h3, 4'h9, 4'h0, 4'h1};
    int need [5] = '{1, 3, 255, 511, 511};
    int up, dn, both, early;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_VOTE_SIZE, {4'h0, code[k]});
      {up, dn, both, early} = '0;
      for (int v = 0; v < need[k] + 4; v++) begin
        eq_vote_up = (v < need[k]) ? 16'h0204 : 16'h0;
        eq_vote_down = (v < need[k]) ? 16'h0280 : 16'h0;
        tick(1);
        up += int'(eq_gain_inc[2]);
        dn += int'(eq_gain_dec[7]);
        both += int'(eq_gain_inc[9] | eq_gain_dec[9]);
        early += int'(eq_gain_inc[2] && v < need[k] - 1);
      end
      chk("inc", 16'h1, 16'(up));
      chk("dec", 16'h1, 16'(dn));
      chk("tie", 16'h0, 16'(both));
      chk("early", 16'h0, 16'(early));
    end
  endtask : t_vote
  task automatic t_phase;
    recovery_phase_bin[5] = 8'h5b;
    debug_lane_select = 4'h5;
    tick(2);
    rd(ADDR_PHASE, 8'h5b ^ 8'h2d, "phase");
    wr(ADDR_FREEZE, 8'h01);
    recovery_phase_bin[5] = 8'hc4;
    tick(2);
    chk("frz", 16'h1, {15'h0, recovery_freeze});
    rd(ADDR_PHASE, 8'h5b ^ 8'h2d, "held");
    wr(ADDR_FREEZE, 8'h00);
    tick(2);
    rd(ADDR_PHASE, 8'hc4 ^ 8'h62, "track");
  endtask : t_phase
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    reg_req = '0;
    {signal_loss_enable, debug_lane_select} = '0;
    {eye_scan_start, eye_scan_mismatch, eye_scan_done, eq_vote_up, eq_vote_down} = '0;
    recovery_phase_bin = '0;
    recovery_phase_bin[4] = 8'hff;
    repeat (4) @(posedge core_clk);
    #1 resetn = 1'b1;
    tick(1);
    t_loss();
    t_count();
    t_vote();
    t_phase();
    final_report();
  end
endmodule : tb_serdes_rx_debug_status_regs
`default_nettype wire
